// ==== sdvf_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdvf_chk (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [19:0] out_data,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        frame_start,
  input wire logic [31:0] fsc_phase,
  input wire logic [31:0] fsc_active,
  input wire logic [2:0]  luma_filter_sel,
  input wire logic [2:0]  chroma_filter_sel,
  input wire logic        prpb_ebf_on,
  input wire logic [3:0]  eb_gain_step,
  input wire logic        sinc_comp_on,
  input wire logic        noninterlaced,
  input wire logic        square_pixel
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [7:0] b0_reg, b1_reg, b2_reg;
  logic [3:0] gain_exp;
  logic       wr_top;
  // mirror of the staged bytes so the applied word can be predicted
  always @(posedge clock) begin
    if (srst) begin
      b0_reg <= 8'h1f;
      b1_reg <= 8'h7c;
      b2_reg <= 8'hf0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h8c) b0_reg <= reg_wdata;
      if (reg_addr == 8'h8d) b1_reg <= reg_wdata;
      if (reg_addr == 8'h8e) b2_reg <= reg_wdata;
    end
  end
  assign gain_exp = (reg_wdata[3:0] > 4'hc) ? 4'hc : reg_wdata[3:0];
  assign wr_top   = reg_wr && reg_addr == 8'h8f;
  property p_fsc_apply;
    wr_top |-> ##2 fsc_active == $past({reg_wdata, b2_reg, b1_reg, b0_reg}, 2);
  endproperty
  a_fsc_apply: assert property (p_fsc_apply) else $error("word not applied");
  property p_fsc_hold;
    !$stable(fsc_active) |-> $past(wr_top, 2);
  endproperty
  a_fsc_hold: assert property (p_fsc_hold) else $error("word changed early");
  // the output stage lags the adder by one cycle, hence the past word
  property p_phase;
    !$past(srst) && !$past(srst, 2)
      |-> fsc_phase == $past(fsc_phase) + $past(fsc_active);
  endproperty
  a_phase: assert property (p_phase) else $error("phase step wrong");
  property p_rd_b0;
    reg_rd && reg_addr == 8'h8c |=> reg_rdata == $past(b0_reg);
  endproperty
  a_rd_b0: assert property (p_rd_b0) else $error("byte 0 readback");
  property p_rd_hole;
    reg_rd && reg_addr == 8'h90 |=> reg_rdata == 8'h00;
  endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  property p_filt;
    reg_wr && reg_addr == 8'h80 |-> ##2
      {chroma_filter_sel, luma_filter_sel} == $past(reg_wdata[7:2], 2);
  endproperty
  a_filt: assert property (p_filt) else $error("filter select wrong");
  property p_mode2;
    reg_wr && reg_addr == 8'h82 |-> ##2
      {square_pixel, prpb_ebf_on} == $past({reg_wdata[4], reg_wdata[0]}, 2);
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 bits wrong");
  property p_nonint;
    reg_wr && reg_addr == 8'h88 |-> ##2 noninterlaced == $past(reg_wdata[1], 2);
  endproperty
  a_nonint: assert property (p_nonint) else $error("noninterlaced wrong");
  property p_sinc;
    reg_wr && reg_addr == 8'h33 |-> ##2 sinc_comp_on == !$past(reg_wdata[3], 2);
  endproperty
  a_sinc: assert property (p_sinc) else $error("sinc enable wrong");
  property p_gain;
    reg_wr && reg_addr == 8'ha2 |-> ##2 eb_gain_step == $past(gain_exp, 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain step wrong");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word lost");
  c_apply: cover property (wr_top);
  c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  c_blank: cover property (out_valid && out_ready && out_data == 20'h10200);
  c_frame: cover property (frame_start);
endmodule // sdvf_chk
bind sdvf_ctrl sdvf_chk chk_u (
  .clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .out_data, .out_valid, .out_ready, .frame_start, .fsc_phase, .fsc_active,
  .luma_filter_sel, .chroma_filter_sel, .prpb_ebf_on, .eb_gain_step,
  .sinc_comp_on, .noninterlaced, .square_pixel
);
`default_nettype wire

// ==== sdvf_ctrl.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sdvf_regs.vh"
// Summary of operation
// RULE_01: vbi enable cleared blanks the whole interval; separate sd and ed/hd bits.
// RULE_02: both vbi enable bits act the same in every master and slave mode.
// RULE_03: progressive 525 passes lines 13-42, 625 passes lines 6-43.
// RULE_04: sd vbi data allowed on lines 10-20 ntsc, 7-22 pal.
// RULE_05: sd slave mode 0 with vbi enabled overwrites the timing code blank bit.
// RULE_06: copy generation info still output when vbi pass-through is off.
// RULE_07: host computes subcarrier word as periods per line over clocks, times 2^32.
// RULE_08: subcarrier word byte 0 is least significant, byte 3 most.
// RULE_09: host writes the subcarrier bytes in ascending order, 0 to 3.
// RULE_10: previous subcarrier kept until byte 3 arrives, then whole word applied.
// RULE_11: host loads typical ntsc or pal subcarrier bytes at 0x8c-0x8f.
// RULE_12: noninterlaced bit accepts 240p or 288p input at double frame rate.
// RULE_13: noninterlaced uses 27 mhz clock; sync from codes or sync pins.
// RULE_14: noninterlaced mode keeps every normal ntsc and pal feature.
// RULE_15: host selects ntsc for 240p, pal for 288p, plus noninterlaced bit.
// RULE_16: square pixel mode uses its own clock; internal timing adjusts.
// RULE_17: sd luma and chroma filter selection through one control register.
// RULE_18: extended band gain enable gives 13 gain steps from a separate register.
// RULE_19: one bit switches the prpb extended band filter; else chroma lpf used.
// RULE_20: ed/hd sinc compensation on by default, one bit turns it off.
// RULE_21: 32-bit accumulator adds active subcarrier word each clock, wraps.
module sdvf_ctrl (
  input  wire        clock,
  input  wire        srst,
  // register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // pixel source
  input  wire [19:0] pix_data,
  input  wire        pix_valid,
  output wire        pix_ready,
  input  wire        line_start,
  input  wire        frame_start,
  input  wire        hd_path,
  input  wire        pal_std,
  input  wire        slave_mode0,
  input  wire        timing_code,
  // processed stream
  output reg  [19:0] out_data,
  output reg         out_valid,
  input  wire        out_ready,
  output reg         out_code_blank,
  // controls to the filter and timing datapath
  output reg  [31:0] fsc_phase,
  output reg  [31:0] fsc_active,
  output reg  [2:0]  luma_filter_sel,
  output reg  [2:0]  chroma_filter_sel,
  output reg         prpb_ebf_on,
  output reg         eb_gain_on,
  output reg  [3:0]  eb_gain_step,
  output reg         sinc_comp_on,
  output reg         noninterlaced,
  output reg         square_pixel,
  output reg  [9:0]  line_number
);
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  reg  [7:0]  filter_reg;
  reg  [7:0]  mode2_reg;
  reg  [7:0]  mode3_reg;
  reg  [7:0]  mode7_reg;
  reg  [7:0]  mode8_reg;
  reg  [7:0]  eb_gain_reg;
  reg  [7:0]  hd_mode1_reg;
  reg  [7:0]  hd_mode3_reg;
  reg  [7:0]  fsc_byte_reg [0:3];
  reg  [31:0] fsc_word_reg;
  reg  [9:0]  line_reg;
  wire [31:0] phase_w;
  wire [1:0]  std_sel;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam [31:0] RST_FSC    = `SDVF_RST_FSC;
  // blanked word: black luma, mid-scale chroma, 10-bit fields
  localparam [19:0] BLANK_WORD = {`SDVF_BLANK_Y, 2'b00,
                                  `SDVF_BLANK_C, 2'b00};
  // codes of {hd_path, pal_std}
  localparam [1:0]  STD_NTSC   = 2'b00;
  localparam [1:0]  STD_PAL    = 2'b01;
  localparam [1:0]  STD_P525   = 2'b10;
  localparam [1:0]  STD_P625   = 2'b11;
  localparam [9:0]  LINE_MAX   = 10'h3ff;

  // in-range check of a line against a window
  function in_win;
    input [9:0] ln;
    input [9:0] lo;
    input [9:0] hi;
    begin
      in_win = (ln >= lo) && (ln <= hi);
    end
  endfunction

  // ---------------------------------------------------------------
  // subcarrier byte staging
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_fsc
      always @(posedge clock) begin
        if (srst) begin
          fsc_byte_reg[gi] <= RST_FSC[8*gi +: 8]; // RULE_08
        end else if (reg_wr &&
                     reg_addr == (`SDVF_ADDR_FSC_BYTE0 + gi)) begin
          fsc_byte_reg[gi] <= reg_wdata; // RULE_08
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (srst) begin
      filter_reg   <= `SDVF_RST_BYTE;
      mode2_reg    <= `SDVF_RST_BYTE;
      mode3_reg    <= `SDVF_RST_BYTE;
      mode7_reg    <= `SDVF_RST_BYTE;
      mode8_reg    <= `SDVF_RST_BYTE;
      eb_gain_reg  <= `SDVF_RST_BYTE;
      hd_mode1_reg <= `SDVF_RST_BYTE;
      hd_mode3_reg <= `SDVF_RST_BYTE;
      fsc_word_reg <= `SDVF_RST_FSC;
    end else if (reg_wr) begin
      case (reg_addr)
        `SDVF_ADDR_SD_FILTER: filter_reg   <= reg_wdata; // RULE_17
        `SDVF_ADDR_SD_MODE2:  mode2_reg    <= reg_wdata;
        `SDVF_ADDR_SD_MODE3:  mode3_reg    <= reg_wdata;
        `SDVF_ADDR_SD_MODE7:  mode7_reg    <= reg_wdata;
        `SDVF_ADDR_SD_MODE8:  mode8_reg    <= reg_wdata;
        `SDVF_ADDR_EB_GAIN:   eb_gain_reg  <= reg_wdata;
        `SDVF_ADDR_HD_MODE1:  hd_mode1_reg <= reg_wdata;
        `SDVF_ADDR_HD_MODE3:  hd_mode3_reg <= reg_wdata;
        // bytes 0-2 are only staged; the word moves as one unit
        `SDVF_ADDR_FSC_BYTE3: fsc_word_reg <= {reg_wdata,
                                               fsc_byte_reg[2],
                                               fsc_byte_reg[1],
                                               fsc_byte_reg[0]}; // RULE_10
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register read-back
  // ---------------------------------------------------------------
  // unmapped subaddresses read zero
  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SDVF_ADDR_SD_FILTER: reg_rdata <= filter_reg;
        `SDVF_ADDR_SD_MODE2:  reg_rdata <= mode2_reg;
        `SDVF_ADDR_SD_MODE3:  reg_rdata <= mode3_reg;
        `SDVF_ADDR_SD_MODE7:  reg_rdata <= mode7_reg;
        `SDVF_ADDR_SD_MODE8:  reg_rdata <= mode8_reg;
        `SDVF_ADDR_EB_GAIN:   reg_rdata <= eb_gain_reg;
        `SDVF_ADDR_HD_MODE1:  reg_rdata <= hd_mode1_reg;
        `SDVF_ADDR_HD_MODE3:  reg_rdata <= hd_mode3_reg;
        `SDVF_ADDR_FSC_BYTE0: reg_rdata <= fsc_byte_reg[0];
        `SDVF_ADDR_FSC_BYTE1: reg_rdata <= fsc_byte_reg[1];
        `SDVF_ADDR_FSC_BYTE2: reg_rdata <= fsc_byte_reg[2];
        `SDVF_ADDR_FSC_BYTE3: reg_rdata <= fsc_byte_reg[3];
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // filter and mode decode
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      luma_filter_sel   <= 3'h0;
      chroma_filter_sel <= 3'h0;
      prpb_ebf_on       <= 1'b0;
      eb_gain_on        <= 1'b0;
      eb_gain_step      <= 4'h0;
      sinc_comp_on      <= 1'b1;
      noninterlaced     <= 1'b0;
      square_pixel      <= 1'b0;
      fsc_active        <= `SDVF_RST_FSC;
    end else begin
      luma_filter_sel   <= filter_reg[4:2]; // RULE_17
      chroma_filter_sel <= filter_reg[7:5]; // RULE_17
      prpb_ebf_on  <= mode2_reg[`SDVF_BIT_PRPB_EBF]; // RULE_19
      eb_gain_on   <= mode7_reg[`SDVF_BIT_EB_GAIN_EN]; // RULE_18
      // out-of-range steps clamp to the top of the 13
      if (eb_gain_reg[3:0] < `SDVF_EB_GAIN_STEPS) begin
        eb_gain_step <= eb_gain_reg[3:0]; // RULE_18
      end else begin
        eb_gain_step <= `SDVF_EB_GAIN_STEPS - 4'h1; // RULE_18
      end
      sinc_comp_on  <= ~hd_mode3_reg[`SDVF_BIT_SINC_DIS]; // RULE_20
      // 240p/288p reuses the ntsc/pal datapath untouched
      noninterlaced <= mode8_reg[`SDVF_BIT_NONINTERLACED]; // RULE_12 RULE_14
      square_pixel  <= mode2_reg[`SDVF_BIT_SQUARE_PIXEL]; // RULE_16
      fsc_active    <= fsc_word_reg; // RULE_10
    end
  end

  // ---------------------------------------------------------------
  // subcarrier phase
  // ---------------------------------------------------------------
  sdvf_fsc_acc u_acc (
    .clock       (clock),
    .srst        (srst),
    .phase_clear (1'b0),
    .fsc_word    (fsc_word_reg),
    .phase       (phase_w)
  );

  always @(posedge clock) begin
    if (srst) begin
      fsc_phase <= 32'h00000000;
    end else begin
      fsc_phase <= phase_w; // RULE_21
    end
  end

  // ---------------------------------------------------------------
  // line counter, fed by codes or sync pins alike
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      line_reg <= 10'h000;
    end else if (frame_start) begin
      line_reg <= 10'h001; // RULE_13
    end else if (line_start && line_reg != LINE_MAX) begin
      // held at the top so a lost frame pulse never wraps into the vbi
      line_reg <= line_reg + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // vbi gating
  // ---------------------------------------------------------------
  reg        vbi_en;
  reg        in_vbi;
  reg        data_ok;
  reg        cgi_line;
  reg        keep;
  reg [19:0] gated;

  assign std_sel = {hd_path, pal_std};

  always @* begin
    // mode bits ignored deliberately: same in master and slave
    vbi_en = hd_path ? hd_mode1_reg[`SDVF_BIT_VBI_EN]
                     : mode3_reg[`SDVF_BIT_VBI_EN]; // RULE_01 RULE_02
    case (std_sel)
      STD_NTSC: begin
        in_vbi   = line_reg < `SDVF_VBI_END_NTSC;
        data_ok  = in_win(line_reg, `SDVF_NTSC_FIRST,
                          `SDVF_NTSC_LAST); // RULE_04
        cgi_line = line_reg == `SDVF_CGI_LINE_NTSC;
      end
      STD_PAL: begin
        in_vbi   = line_reg < `SDVF_VBI_END_PAL;
        data_ok  = in_win(line_reg, `SDVF_PAL_FIRST,
                          `SDVF_PAL_LAST); // RULE_04
        cgi_line = line_reg == `SDVF_CGI_LINE_PAL;
      end
      STD_P525: begin
        in_vbi   = line_reg < `SDVF_VBI_END_P525;
        data_ok  = in_win(line_reg, `SDVF_P525_FIRST,
                          `SDVF_P525_LAST); // RULE_03
        cgi_line = line_reg == `SDVF_CGI_LINE_P525;
      end
      STD_P625: begin
        in_vbi   = line_reg < `SDVF_VBI_END_P625;
        data_ok  = in_win(line_reg, `SDVF_P625_FIRST,
                          `SDVF_P625_LAST); // RULE_03
        cgi_line = line_reg == `SDVF_CGI_LINE_P625;
      end
      default: begin
        // both select bits are two-valued; never taken
        in_vbi   = 1'b0;
        data_ok  = 1'b0;
        cgi_line = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // blank decision
  // ---------------------------------------------------------------
  // decided at acceptance, so the buffer carries the result
  always @* begin
    keep  = ~in_vbi | (vbi_en & data_ok) |
            (cgi_line & mode3_reg[`SDVF_BIT_CGI_EN]); // RULE_01 RULE_06
    gated = keep ? pix_data : BLANK_WORD; // RULE_01
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  wire [19:0] buf_data;
  wire        buf_valid;
  wire        buf_ready;

  assign buf_ready = ~out_valid | out_ready;

  sdvf_skid u_skid (
    .clock     (clock),
    .srst      (srst),
    .in_data   (gated),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  always @(posedge clock) begin
    if (srst) begin
      out_data       <= 20'h00000;
      out_valid      <= 1'b0;
      out_code_blank <= 1'b0;
      line_number    <= 10'h000;
    end else begin
      line_number <= line_reg;
      if (buf_ready) begin
        out_data  <= buf_data;
        out_valid <= buf_valid;
        // slave mode 0: regenerated blank bit lets vbi lines through
        // only the sd path carries a slave mode 0 code
        out_code_blank <= timing_code & slave_mode0 & ~hd_path &
                          in_vbi & ~(vbi_en & data_ok); // RULE_05
      end
    end
  end
endmodule // sdvf_ctrl
`default_nettype wire

// ==== sdvf_ctrl_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdvf_ctrl_bench;
  logic        clock, srst, reg_wr, reg_rd, hd_path, pal_std, slave_mode0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, a, d;
  logic [19:0] pix_data, out_data, d20;
  logic        pix_valid, pix_ready, line_start, frame_start, out_valid;
  logic        out_ready, out_code_blank, prpb_ebf_on, eb_gain_on, cgi;
  logic        sinc_comp_on, noninterlaced, square_pixel, timing_code;
  logic [31:0] fsc_phase, fsc_active, nw, old;
  logic [2:0]  luma_filter_sel, chroma_filter_sel;
  logic [3:0]  eb_gain_step;
  logic [9:0]  line_number;
  logic [7:0]  cfg [6] = '{8'h80, 8'h82, 8'h87, 8'h88, 8'ha2, 8'h33};
  logic [19:0] exp_q [$];
  int          n_mismatch, samples_checked;
  sdvf_ctrl dut_u (
    .clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .pix_data, .pix_valid, .pix_ready, .line_start, .frame_start, .hd_path,
    .pal_std, .slave_mode0, .timing_code, .out_data, .out_valid,
    .out_ready, .out_code_blank, .fsc_phase, .fsc_active, .luma_filter_sel,
    .chroma_filter_sel, .prpb_ebf_on, .eb_gain_on, .eb_gain_step,
    .sinc_comp_on, .noninterlaced, .square_pixel, .line_number
  );
  sdvf_pix_src src_u (
    .clock, .pix_ready, .pix_data, .pix_valid, .line_start, .frame_start,
    .out_ready
  );
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= dt;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rv = reg_rdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask
  function automatic logic [31:0] fsc_word(input real per, input real clk);
    return 32'($rtoi(per / clk * 4294967296.0 + 0.5));
  endfunction
  function automatic logic [19:0] exp_word(input logic [19:0] dw, input int l,
      input logic hd, input logic pal, input logic vbi, input logic cg);
    int f, la, e, c;
    f  = hd ? (pal ? 6 : 13) : (pal ? 7 : 10);
    la = hd ? (pal ? 43 : 42) : (pal ? 22 : 20);
    e  = hd ? (pal ? 44 : 43) : (pal ? 23 : 21);
    c  = hd ? (pal ? 43 : 41) : (pal ? 22 : 20);
    if (l >= e || (vbi && l >= f && l <= la) || (cg && l == c))
      return dw;
    return 20'h10200;
  endfunction
  task automatic finish_test;
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra word", 32'h0, 32'h1);
      else chk("out_data", 32'(exp_q.pop_front()), 32'(out_data));
    end
  end
  initial begin
    #1000000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    hd_path = 1'b0;
    pal_std = 1'b0;
    slave_mode0 = 1'b0;
    timing_code = 1'b0;
    void'($urandom(14));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    chk("fsc_active", fsc_word(227.5, 1716.0), fsc_active);
    chk("sinc_comp_on", 32'h1, 32'(sinc_comp_on));
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h8c + i));
      chk("fsc byte", 32'(8'(32'h21f07c1f >> (8 * i))), 32'(rv));
    end
    for (int k = 0; k < 2; k++) begin
      old = fsc_active;
      nw  = k ? $urandom : 32'h2a098acb;
      for (int i = 0; i < 4; i++) begin
        wr(8'(8'h8c + i), nw[8*i +: 8]);
        settle;
        chk("fsc_active", (i == 3) ? nw : old, fsc_active);
      end
      for (int i = 0; i < 4; i++) begin
        rd(8'(8'h8c + i));
        chk("fsc byte", 32'(nw[8*i +: 8]), 32'(rv));
      end
    end
    wr(8'h90, 8'hff);
    rd(8'h90);
    chk("unmapped", 32'h0, 32'(rv));
    for (int i = 0; i < 24; i++) begin
      a = cfg[i % 6];
      d = (i == 4) ? 8'hff : 8'($urandom);
      wr(a, d);
      settle;
      if (a == 8'h87) chk("eb_gain_on", 32'(d[4]), 32'(eb_gain_on));
    end
    for (int p = 0; p < 8; p++) begin
      cgi = 1'($urandom);
      // the two blanking enables are set opposite to prove they are separate
      wr(8'h83, {3'h0, p[2], 3'h0, cgi});
      wr(8'h31, {3'h0, !p[2], 4'h0});
      wr(8'h88, {6'h0, 1'($urandom), 1'b0});
      @(posedge clock);
      hd_path     <= p[0];
      pal_std     <= p[1];
      slave_mode0 <= 1'($urandom);
      src_u.pulse(1'b1);
      timing_code <= 1'b1;
      settle;
      // line 1 lies outside every data window, so the code is blanked in sd slave mode 0
      old = 32'(slave_mode0 && !p[0]);
      chk("code blank", old, 32'(out_code_blank));
      chk("line_number", 32'h1, 32'(line_number));
      @(posedge clock);
      timing_code <= 1'b0;
      for (int ln = 1; ln <= 45; ln++) begin
        if (ln > 1) src_u.pulse(1'b0);
        d20 = 20'($urandom);
        exp_q.push_back(exp_word(d20, ln, p[0], p[1], p[0] ^ p[2], cgi));
        src_u.send(d20);
      end
      for (int t = 0; t < 100 && exp_q.size() > 0; t++) @(posedge clock);
      chk("drained", 32'h0, 32'(exp_q.size()));
      timing_code <= 1'b1;
      settle;
      // past the interval the code must never be forced to blank
      chk("code blank", 32'h0, 32'(out_code_blank));
      chk("line_number", 32'h2d, 32'(line_number));
      @(posedge clock);
      timing_code <= 1'b0;
    end
    finish_test;
  end
endmodule // sdvf_ctrl_bench
`default_nettype wire

// ==== sdvf_fsc_acc.v ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// subcarrier phase accumulator
// ---------------------------------------------------------------
module sdvf_fsc_acc (
  input  wire        clock,
  input  wire        srst,
  input  wire        phase_clear,
  input  wire [31:0] fsc_word,
  output reg  [31:0] phase
);
  // natural wrap of the 32-bit sum gives modulo 2^32
  always @(posedge clock) begin
    if (srst | phase_clear) begin
      phase <= 32'h00000000;
    end else begin
      phase <= phase + fsc_word; // RULE_21
    end
  end
endmodule // sdvf_fsc_acc
`default_nettype wire

// ==== sdvf_pix_src.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdvf_pix_src (
  input  wire logic        clock,
  input  wire logic        pix_ready,
  output var  logic [19:0] pix_data,
  output var  logic        pix_valid,
  output var  logic        line_start,
  output var  logic        frame_start,
  output var  logic        out_ready
);
  initial begin
    pix_data    = 20'h00000;
    pix_valid   = 1'b0;
    line_start  = 1'b0;
    frame_start = 1'b0;
    out_ready   = 1'b0;
  end
  // sink stalls about one cycle in four so the buffer fills
  always @(posedge clock) out_ready <= ($urandom % 4) != 0;
  task automatic pulse(input logic frame);
    @(posedge clock);
    frame_start <= frame;
    line_start  <= !frame;
    @(posedge clock);
    frame_start <= 1'b0;
    line_start  <= 1'b0;
  endtask
  task automatic send(input logic [19:0] d);
    @(posedge clock);
    pix_valid <= 1'b1;
    pix_data  <= d;
    @(negedge clock);
    while (pix_ready !== 1'b1) begin
      @(posedge clock);
      @(negedge clock);
    end
    @(posedge clock);
    pix_valid <= 1'b0;
    // released data is scrambled so a stale word cannot pass
    pix_data  <= ~d;
  endtask
endmodule // sdvf_pix_src
`default_nettype wire

// ==== sdvf_regs.vh ====
`ifndef SDVF_REGS_VH
`define SDVF_REGS_VH
// ---------------------------------------------------------------
// register offsets (8-bit subaddress)
// ---------------------------------------------------------------
`define SDVF_ADDR_SD_FILTER     8'h80
`define SDVF_ADDR_SD_MODE2      8'h82
`define SDVF_ADDR_SD_MODE3      8'h83
`define SDVF_ADDR_SD_MODE7      8'h87
`define SDVF_ADDR_SD_MODE8      8'h88
`define SDVF_ADDR_FSC_BYTE0     8'h8c
`define SDVF_ADDR_FSC_BYTE1     8'h8d
`define SDVF_ADDR_FSC_BYTE2     8'h8e
`define SDVF_ADDR_FSC_BYTE3     8'h8f
`define SDVF_ADDR_EB_GAIN       8'ha2
`define SDVF_ADDR_HD_MODE1      8'h31
`define SDVF_ADDR_HD_MODE3      8'h33
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SDVF_BIT_VBI_EN         4
`define SDVF_BIT_NONINTERLACED  1
`define SDVF_BIT_SQUARE_PIXEL   4
`define SDVF_BIT_PRPB_EBF       0
`define SDVF_BIT_EB_GAIN_EN     4
`define SDVF_BIT_SINC_DIS       3
`define SDVF_BIT_CGI_EN         0
// ---------------------------------------------------------------
// reset values and the gain step count
// ---------------------------------------------------------------
`define SDVF_RST_FSC            32'h21f07c1f
`define SDVF_RST_BYTE           8'h00
`define SDVF_EB_GAIN_STEPS      4'hd
// ---------------------------------------------------------------
// vbi line windows, cgi lines, interval ends and blank levels
// ---------------------------------------------------------------
`define SDVF_P525_FIRST         10'h00d
`define SDVF_P525_LAST          10'h02a
`define SDVF_P625_FIRST         10'h006
`define SDVF_P625_LAST          10'h02b
`define SDVF_NTSC_FIRST         10'h00a
`define SDVF_NTSC_LAST          10'h014
`define SDVF_PAL_FIRST          10'h007
`define SDVF_PAL_LAST           10'h016
`define SDVF_CGI_LINE_NTSC      10'h014
`define SDVF_CGI_LINE_PAL       10'h016
`define SDVF_CGI_LINE_P525      10'h029
`define SDVF_CGI_LINE_P625      10'h02b
`define SDVF_VBI_END_NTSC       10'h015
`define SDVF_VBI_END_PAL        10'h017
`define SDVF_VBI_END_P525       10'h02b
`define SDVF_VBI_END_P625       10'h02c
`define SDVF_BLANK_Y            8'h10
`define SDVF_BLANK_C            8'h80
`endif

// ==== sdvf_skid.v ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// two-entry buffer, full throughput, no word lost on a stall
// ---------------------------------------------------------------
module sdvf_skid (
  input  wire        clock,
  input  wire        srst,
  input  wire [19:0] in_data,
  input  wire        in_valid,
  output wire        in_ready,
  output wire [19:0] out_data,
  output wire        out_valid,
  input  wire        out_ready
);
  reg  [19:0] mem_reg [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  count_reg;
  reg         ready_reg;
  wire [1:0]  count_next;
  wire        push;
  wire        pop;

  // ready is registered so the port comes straight from a flip-flop
  assign in_ready   = ready_reg;
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
  assign out_valid = (count_reg != 2'd0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
      ready_reg  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != 2'd2);
    end
  end
endmodule // sdvf_skid
`default_nettype wire
